// ### core_req_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_req_model (
    input  wire io_space_pkg::io_rsp_t rsp,
    input  wire logic                  sys_clk,
    output var io_space_pkg::io_req_t  req
);
    initial req = '0;
    // Callers store only to mapped places and send reserved bits as zero.
    task automatic xfer(input io_space_pkg::io_op_t op, input io_space_pkg::bit_op_t bop, input logic [7:0] a,
        input logic [2:0] s, input logic [7:0] wd, output io_space_pkg::io_rsp_t got);
        @(posedge sys_clk);
        req <= '{1'b1, op, bop, a, s, wd};
        @(posedge sys_clk);
        req.valid <= 1'b0;
        #1 got = rsp;
    endtask : xfer
endmodule : core_req_model
`default_nettype wire

// ### io_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_space_cfg.svh"

module io_addr_map (
    input  wire logic                      short_form,
    input  wire logic [7:0]                addr,
    output logic      [7:0]                data_addr,
    output logic                           legal,
    output logic                           bit_ok
);
    // Short-form I/O addresses are folded into the data view so one decoder serves both.
    wire [7:0] shifted_addr = addr + `IO_DATA_OFFSET; // RULE_05

    assign data_addr = short_form ? shifted_addr : addr;
    assign legal     = short_form ? (addr[7:6] == 2'b00) : (addr >= `IO_DATA_FIRST); // RULE_04 RULE_06
    assign bit_ok    = short_form && (addr[7:5] == 3'b000); // RULE_02

endmodule : io_addr_map
`default_nettype wire

// ### io_space_cfg.svh
`ifndef IO_SPACE_CFG_SVH
`define IO_SPACE_CFG_SVH

`define IO_SHORT_LAST       6'h3F
`define IO_BIT_LAST         6'h1F
`define IO_DATA_OFFSET      8'h20
`define IO_DATA_FIRST       8'h20
`define IO_DATA_LAST        8'h5F
`define IO_EXT_FIRST        8'h60
`define SCRATCH_ZERO_IO     6'h1E
`define SCRATCH_ONE_IO      6'h2A
`define SCRATCH_TWO_IO      6'h2B
`define FLAG_REG_IO         6'h1C
`define EXT_REG_DATA        8'h60
`define BYTE_RESET          8'h00
`define FLAG_RESET          8'h00
`define EXT_RESET           8'h00

`endif

// ### io_space_pkg.sv
`default_nettype none
package io_space_pkg;

    typedef enum logic [4:0] {
        OP_IN    = 5'h01,
        OP_OUT   = 5'h02,
        OP_LOAD  = 5'h04,
        OP_STORE = 5'h08,
        OP_BIT   = 5'h10
    } io_op_t;

    typedef enum logic [3:0] {
        BIT_SET       = 4'h1,
        BIT_CLEAR     = 4'h2,
        BIT_SKIP_SET  = 4'h4,
        BIT_SKIP_CLR  = 4'h8
    } bit_op_t;

    typedef struct packed {
        logic    valid;
        io_op_t  op;
        bit_op_t bit_op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       skip;
        logic       hit;
    } io_rsp_t;

endpackage : io_space_pkg
`default_nettype wire

// ### io_space_register_decode.sv
// How it works
// RULE_01: Load and store reach every I/O location, moving one byte between a working register and it.
// RULE_02: Locations 0x00 to 0x1F take single-bit set and clear from the core.
// RULE_03: In that low range the core may test one bit and skip on set or on clear.
// RULE_04: The short I/O read and write forms address only 0x00 to 0x3F, 64 locations.
// RULE_05: Through the data space an I/O register sits at its I/O address plus 0x20.
// RULE_06: The extended region 0x60 to 0xFF answers only to load and store.
// RULE_07: Registers beyond the short range are placed only in the extended region.
// RULE_08: Software should write zero to reserved bits.
// RULE_09: Software never writes reserved addresses.
// RULE_10: Some status flags clear on a written one and ignore a written zero.
// RULE_11: Single-bit set or clear touches only the addressed bit.
// RULE_12: Three 8-bit scratch registers hold whatever software stores.
// RULE_13: Each scratch register is fully read/write, resets to zero and reads back its last value.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_cfg.svh"

module io_space_register_decode (
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    input  wire io_space_pkg::io_req_t     req,
    input  wire logic [7:0]                flag_events,
    output io_space_pkg::io_rsp_t          rsp,
    output logic [7:0]                     flag_status,
    output logic [7:0]                     ext_ctrl
);

    logic [7:0]           scratch_reg_zero_ff;
    logic [7:0]           scratch_reg_one_ff;
    logic [7:0]           scratch_reg_two_ff;
    logic [7:0]           flag_ff;
    logic [7:0]           ext_ff;
    io_space_pkg::io_rsp_t rsp_ff;

    wire        short_form = (req.op == io_space_pkg::OP_IN) || (req.op == io_space_pkg::OP_OUT) ||
                             (req.op == io_space_pkg::OP_BIT);
    wire [7:0]  data_addr;
    wire        legal;
    wire        bit_ok;

    io_addr_map u_map (
        .short_form (short_form),
        .addr       (req.addr),
        .data_addr  (data_addr),
        .legal      (legal),
        .bit_ok     (bit_ok)
    );

    function automatic logic hit_io(input logic [7:0] a, input logic [5:0] io);
        hit_io = (a == ({2'b00, io} + `IO_DATA_OFFSET)); // RULE_05
    endfunction : hit_io

    wire do_write = req.valid && legal && ((req.op == io_space_pkg::OP_OUT) || (req.op == io_space_pkg::OP_STORE)); // RULE_01 RULE_04
    wire do_bit   = req.valid && bit_ok && (req.op == io_space_pkg::OP_BIT); // RULE_02
    wire do_read  = req.valid && legal && ((req.op == io_space_pkg::OP_IN) || (req.op == io_space_pkg::OP_LOAD));

    wire sel_s0   = hit_io(data_addr, `SCRATCH_ZERO_IO);
    wire sel_s1   = hit_io(data_addr, `SCRATCH_ONE_IO);
    wire sel_s2   = hit_io(data_addr, `SCRATCH_TWO_IO);
    wire sel_flag = hit_io(data_addr, `FLAG_REG_IO);
    // The extended register lives only above the short window, so the short forms can never reach it.
    wire sel_ext  = !short_form && (data_addr == `EXT_REG_DATA); // RULE_06 RULE_07
    wire hit      = sel_s0 || sel_s1 || sel_s2 || sel_flag || sel_ext;

    wire [7:0] bit_mask = 8'h01 << req.bit_sel;
    wire       is_set   = req.bit_op == io_space_pkg::BIT_SET;
    wire       is_clr   = req.bit_op == io_space_pkg::BIT_CLEAR;

    function automatic logic [7:0] bit_update(input logic [7:0] cur, input logic [7:0] m,
                                              input logic s, input logic c);
        bit_update = s ? (cur | m) : (c ? (cur & ~m) : cur); // RULE_11
    endfunction : bit_update

    wire [7:0] read_mux = sel_s0   ? scratch_reg_zero_ff :
                          sel_s1   ? scratch_reg_one_ff  :
                          sel_s2   ? scratch_reg_two_ff  :
                          sel_flag ? flag_ff             :
                          sel_ext  ? ext_ff              : `BYTE_RESET;

    // Of the scratch registers, bit ops reach only scratch register zero and rewrite only the chosen bit.
    wire [7:0] nxt_s0 = (do_write && sel_s0) ? req.wdata :
                        (do_bit && sel_s0) ? bit_update(scratch_reg_zero_ff, bit_mask, is_set, is_clr) :
                        scratch_reg_zero_ff; // RULE_12 RULE_13
    wire [7:0] nxt_s1 = (do_write && sel_s1) ? req.wdata : scratch_reg_one_ff; // RULE_12 RULE_13
    wire [7:0] nxt_s2 = (do_write && sel_s2) ? req.wdata : scratch_reg_two_ff; // RULE_12 RULE_13
    wire [7:0] nxt_ext = (do_write && sel_ext) ? req.wdata : ext_ff;

    // Write-one clears; a bit op clears only the one bit named by a set, never the others.
    // A new event in the same cycle wins over the clear.
    wire [7:0] flag_clr = (do_write && sel_flag) ? req.wdata :
                          (do_bit && sel_flag && is_set) ? bit_mask : `FLAG_RESET; // RULE_10 RULE_11
    wire [7:0] nxt_flag = (flag_ff & ~flag_clr) | flag_events; // RULE_10

    wire       tested   = |(read_mux & bit_mask);
    wire       skip_req = do_bit && ((req.bit_op == io_space_pkg::BIT_SKIP_SET && tested) ||
                                     (req.bit_op == io_space_pkg::BIT_SKIP_CLR && !tested)); // RULE_03

    io_space_pkg::io_rsp_t nxt_rsp;
    assign nxt_rsp.valid = req.valid;
    assign nxt_rsp.rdata = do_read ? read_mux : `BYTE_RESET; // RULE_01
    assign nxt_rsp.skip  = skip_req;
    // A bit op outside the low window is ignored, so it must not report a decoded register either.
    wire       bit_range_ok = (req.op != io_space_pkg::OP_BIT) || bit_ok; // RULE_02
    assign nxt_rsp.hit   = req.valid && legal && hit && bit_range_ok;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scratch_reg_zero_ff <= `BYTE_RESET;
            scratch_reg_one_ff  <= `BYTE_RESET;
            scratch_reg_two_ff  <= `BYTE_RESET;
            flag_ff             <= `FLAG_RESET;
            ext_ff              <= `EXT_RESET;
            rsp_ff              <= '0;
        end else begin
            scratch_reg_zero_ff <= nxt_s0;
            scratch_reg_one_ff  <= nxt_s1;
            scratch_reg_two_ff  <= nxt_s2;
            flag_ff             <= nxt_flag;
            ext_ff              <= nxt_ext;
            rsp_ff              <= nxt_rsp;
        end
    end

    assign rsp         = rsp_ff;
    assign flag_status = flag_ff;
    assign ext_ctrl    = ext_ff;

endmodule : io_space_register_decode
`default_nettype wire

// ### io_space_register_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none
module io_space_register_decode_sva (
    input wire logic                  sys_clk,
    input wire logic                  sys_rst,
    input wire io_space_pkg::io_req_t req,
    input wire logic [7:0]            flag_events,
    input wire io_space_pkg::io_rsp_t rsp,
    input wire logic [7:0]            flag_status,
    input wire logic [7:0]            ext_ctrl
);
    wire logic in_op = req.valid && req.op == io_space_pkg::OP_IN;
    wire logic ot_op = req.valid && req.op == io_space_pkg::OP_OUT;
    wire logic ld_op = req.valid && req.op == io_space_pkg::OP_LOAD;
    wire logic st_op = req.valid && req.op == io_space_pkg::OP_STORE;
    wire logic bt_op = req.valid && req.op == io_space_pkg::OP_BIT;
    wire logic quiet = flag_events == 8'h00;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_rsp_follows: assert property (req.valid |=> rsp.valid) else $error("no response");
    a_idle_quiet: assert property (!req.valid |=> !rsp.valid) else $error("stray response");
    a_write_nodata: assert property (st_op || ot_op || bt_op |=> rsp.rdata == 8'h00) else $error("rdata");
    a_short_range: assert property (in_op && req.addr > 8'h3F |=> !rsp.hit) else $error("short hit");
    a_low_load: assert property (ld_op && req.addr < 8'h20 |=> !rsp.hit) else $error("low load hit");
    a_ext_store: assert property (st_op && req.addr == 8'h60 |=> ext_ctrl == $past(req.wdata)) else $error("ext");
    a_out_no_ext: assert property (ot_op |=> $stable(ext_ctrl)) else $error("out reached ext");
    a_bit_range: assert property (bt_op && req.addr > 8'h1F |=> !rsp.hit) else $error("bit hit");
    a_flag_clear: assert property (ot_op && req.addr == 8'h1C && quiet
        |=> flag_status == ($past(flag_status) & ~$past(req.wdata))) else $error("w1c");
    a_bit_single: assert property (bt_op && req.bit_op == io_space_pkg::BIT_SET && req.addr == 8'h1C && quiet
        |=> flag_status == ($past(flag_status) & ~(8'h01 << $past(req.bit_sel)))) else $error("bit");
    cover property (st_op && req.addr == 8'h60);
    cover property (rsp.skip);
    cover property (bt_op && req.addr == 8'h1C);
endmodule : io_space_register_decode_sva
bind io_space_register_decode io_space_register_decode_sva io_space_register_decode_sva_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .req(req), .flag_events(flag_events), .rsp(rsp), .flag_status(flag_status),
    .ext_ctrl(ext_ctrl));
`default_nettype wire

// ### io_space_register_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module io_space_register_decode_tb;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [7:0]            flag_events = 8'h00;
    logic [7:0]            flag_status, ext_ctrl;
    io_space_pkg::io_req_t req;
    io_space_pkg::io_rsp_t rsp, got;
    int                    bad_count = 0;
    int                    tests_run = 0;
    always #10 sys_clk = ~sys_clk;
    core_req_model core_req_model_i (.sys_clk(sys_clk), .rsp(rsp), .req(req));
    io_space_register_decode io_space_register_decode_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
        .flag_events(flag_events), .rsp(rsp), .flag_status(flag_status), .ext_ctrl(ext_ctrl));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic go(input io_space_pkg::io_op_t op, input logic [7:0] a, input logic [7:0] wd);
        core_req_model_i.xfer(op, io_space_pkg::BIT_SET, a, 3'h0, wd, got);
    endtask : go
    task automatic bop(input io_space_pkg::bit_op_t b, input logic [7:0] a, input logic [2:0] s);
        core_req_model_i.xfer(io_space_pkg::OP_BIT, b, a, s, 8'h00, got);
    endtask : bop
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        go(io_space_pkg::OP_LOAD, 8'h3E, 8'h00); chk(got.rdata, 8'h00);
        go(io_space_pkg::OP_LOAD, 8'h4A, 8'h00); chk(got.rdata, 8'h00);
        go(io_space_pkg::OP_IN, 8'h2B, 8'h00); chk(got.rdata, 8'h00);
        go(io_space_pkg::OP_STORE, 8'h3E, 8'hA5); chk({7'h00, got.hit}, 8'h01);
        chk({7'h00, got.valid}, 8'h01);
        go(io_space_pkg::OP_IN, 8'h1E, 8'h00); chk(got.rdata, 8'hA5);
        go(io_space_pkg::OP_OUT, 8'h2A, 8'h5A);
        go(io_space_pkg::OP_LOAD, 8'h4A, 8'h00); chk(got.rdata, 8'h5A);
        go(io_space_pkg::OP_STORE, 8'h4B, 8'hFF);
        go(io_space_pkg::OP_IN, 8'h2B, 8'h00); chk(got.rdata, 8'hFF);
        go(io_space_pkg::OP_LOAD, 8'h10, 8'h00); chk({7'h00, got.hit}, 8'h00);
        go(io_space_pkg::OP_STORE, 8'h60, 8'h3C); chk(ext_ctrl, 8'h3C);
        go(io_space_pkg::OP_LOAD, 8'h60, 8'h00); chk(got.rdata, 8'h3C);
        go(io_space_pkg::OP_IN, 8'h60, 8'h00); chk(got.rdata, 8'h00);
        chk({7'h00, got.hit}, 8'h00);
        bop(io_space_pkg::BIT_SET, 8'h1E, 3'h1);
        bop(io_space_pkg::BIT_CLEAR, 8'h1E, 3'h7);
        go(io_space_pkg::OP_IN, 8'h1E, 8'h00); chk(got.rdata, 8'h27);
        bop(io_space_pkg::BIT_SKIP_SET, 8'h1E, 3'h1); chk({7'h00, got.skip}, 8'h01);
        bop(io_space_pkg::BIT_SKIP_CLR, 8'h1E, 3'h1); chk({7'h00, got.skip}, 8'h00);
        bop(io_space_pkg::BIT_SKIP_CLR, 8'h1E, 3'h3); chk({7'h00, got.skip}, 8'h01);
        bop(io_space_pkg::BIT_SET, 8'h2A, 3'h0); chk({7'h00, got.hit}, 8'h00);
        @(posedge sys_clk) flag_events <= 8'h83;
        @(posedge sys_clk) flag_events <= 8'h00;
        go(io_space_pkg::OP_OUT, 8'h1C, 8'h01); chk(flag_status, 8'h82);
        go(io_space_pkg::OP_OUT, 8'h1C, 8'h00); chk(flag_status, 8'h82);
        bop(io_space_pkg::BIT_SET, 8'h1C, 3'h7); chk(flag_status, 8'h02);
        bop(io_space_pkg::BIT_CLEAR, 8'h1C, 3'h1); chk(flag_status, 8'h02);
        go(io_space_pkg::OP_STORE, 8'h3C, 8'h02); chk(flag_status, 8'h00);
        complete_run();
    end
endmodule : io_space_register_decode_tb
`default_nettype wire
